// File: rtl/dsec_core.sv
// drive operating-state machine, error class responses and stop-cause record
// How it works
// - entering fault via an error starts a response chosen by its class
// - class 0 only raises a warning; motion and power stage continue
// - class 1 quick-stops; power stage and controller stay enabled
// - class 2 quick-stops, then disables power stage at standstill
// - class 3 switches power stage off at once, no stop first
// - class 4 switches off at once; only power cycle clears it
// - limit input trip in state 6 enters quick stop, records A302 cause and history
// - class 1 error in state 6 or 7 enters quick stop, records cause and history
// - error above class 1 enters fault reaction, records cause and history
// - keep last stop cause and ten newest error codes, oldest dropped
// - display sees last stop cause; fieldbus sees cause and history
// - after reset state 1 start, then state 2 not ready
// - state 3 blocks enable; state 4 reports ready to switch on
// - state 5 keeps motor unpowered, power stage ready, no mode
// - state 6 runs mode or halts powered; halt records nothing
// - state 7 quick stop, 8 fault reaction, 9 settled fault
// - only inputs, fieldbus commands or monitors change state
// - monitors may force state changes in any state but start
// - 1 to 2 on electronics ready, 2 to 3 on parameters ready
// - enable request takes 4 to 5, then automatically to 6
// - 8 to 9 after class 2 response ends, at once for 3 or 4
// - fault reset takes 9 to 3 once the cause is removed
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dsec_regs.svh"
module dsec_core #(
  parameter int HIST_DEPTH = `DSEC_HIST_DEPTH
) (
  input wire logic aclk,
  input wire logic aclken,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and monitors
  input wire logic positive_limit_input,
  input wire logic negative_limit_input,
  input wire logic power_ok,
  input wire logic enable_input,
  input wire logic fault_reset_input,
  input wire logic error_event,
  input wire dsec_pkg::dsec_class_t error_class,
  input wire logic [15:0] error_code,
  input wire logic error_active,
  input wire logic standstill,
  // drive outputs
  output dsec_pkg::dsec_state_t op_state,
  output logic power_stage_en,
  output logic brake_release,
  output logic mode_run,
  output logic quick_stop,
  output logic warning,
  output logic halted_indication,
  output logic fault_indication,
  output logic ready_indication,
  output logic [15:0] display_code
);
  import dsec_pkg::*;

  typedef struct packed {
    dsec_state_t st;
    dsec_class_t react_cls;
    logic latch4;
    logic warn;
    logic halt;
    logic elec_ok;
    logic par_ok;
    logic [15:0] stop_cause;
    logic [15:0] last_err;
    logic [3:0] wptr;
    logic [3:0] count;
    logic limit_prev;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic rpend;
    logic rvalid;
    logic [31:0] rdata;
    logic [7:0] araddr;
  } dsec_core_t;

  dsec_core_t s_q, s_d;
  logic [4:0] pins_s;
  logic [15:0] hist_rd;
  logic hist_we;
  logic [3:0] hist_ra;
  logic [15:0] hist_wd;

  // limits, power and local buttons come from outside the clock domain
  dsec_sync #(.W(5)) u_sync (
    .aclk(aclk),
    .aclken(aclken),
    .aresetn(aresetn),
    .din({positive_limit_input, negative_limit_input, power_ok, enable_input,
          fault_reset_input}),
    .dout(pins_s)
  );

  dsec_hist_mem #(.DEPTH(HIST_DEPTH), .AW(4)) u_hist (
    .aclk(aclk),
    .aclken(aclken),
    .wr_en(hist_we),
    .wr_addr(s_q.wptr),
    .wr_data(hist_wd),
    .rd_addr(hist_ra),
    .rd_data(hist_rd)
  );

  // history slot n counts back from the newest entry
  function automatic logic [3:0] hist_slot(input logic [3:0] wptr, input logic [3:0] n);
    logic [4:0] t;
    t = {1'b0, wptr} + 5'(HIST_DEPTH) - 5'd1 - {1'b0, n};
    if (t >= 5'(HIST_DEPTH)) begin
      t = t - 5'(HIST_DEPTH);
    end
    return t[3:0];
  endfunction

  logic lim_now, pwr, en_pin, rst_pin;
  logic wr_fire, rd_fire, ctl_wr;
  logic [31:0] ctl;
  logic en_req, dis_req, rst_req, rec_err;
  logic [15:0] rec_code;

  always_comb begin
    s_d = s_q;
    lim_now = pins_s[4] | pins_s[3];
    pwr = pins_s[2];
    en_pin = pins_s[1];
    rst_pin = pins_s[0];
    hist_we = 1'b0;
    hist_wd = 16'h0000;
    rec_err = 1'b0;
    rec_code = 16'h0000;
    // bus write: address and data may arrive in either order
    if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
    end
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    ctl_wr = wr_fire && s_q.awaddr == `DSEC_OFS_CTRL;
    ctl = ctl_wr ? s_q.wdata : 32'h0000_0000;
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // fieldbus commands and local inputs are the only requesters
    en_req = ctl[`DSEC_CTRL_ENABLE] | en_pin;
    dis_req = ctl[`DSEC_CTRL_DISABLE];
    rst_req = ctl[`DSEC_CTRL_RESET] | rst_pin;
    if (ctl_wr) begin
      s_d.halt = ctl[`DSEC_CTRL_HALT];
      s_d.elec_ok = s_q.elec_ok | ctl[`DSEC_CTRL_ELEC_OK];
      s_d.par_ok = s_q.par_ok | ctl[`DSEC_CTRL_PAR_OK];
    end
    s_d.limit_prev = lim_now;
    if (error_event) begin
      s_d.warn = (error_class == 3'd0);
    end
    case (s_q.st)
      ST_START: begin
        if (s_q.elec_ok) begin
          s_d.st = ST_NOT_READY;
        end
      end
      ST_NOT_READY: begin
        if (s_q.par_ok) begin
          s_d.st = ST_SW_DISABLED;
        end
      end
      ST_SW_DISABLED: begin
        if (pwr && !lim_now) begin
          s_d.st = ST_READY; // enable ignored here
        end
      end
      ST_READY: begin
        if (!pwr) begin
          s_d.st = ST_SW_DISABLED;
        end else if (en_req) begin
          s_d.st = ST_SWITCHED_ON;
        end
      end
      ST_SWITCHED_ON: begin
        if (dis_req || !pwr) begin
          s_d.st = ST_SW_DISABLED;
        end else begin
          s_d.st = ST_OP_ENABLED;
        end
      end
      ST_OP_ENABLED: begin
        if (dis_req || !pwr) begin
          s_d.st = ST_SW_DISABLED;
        end else if (ctl[`DSEC_CTRL_SW_STOP]) begin
          s_d.st = ST_QSTOP;
          s_d.stop_cause = `DSEC_CODE_SWSTOP;
        end
      end
      ST_QSTOP: begin
        if (dis_req || !pwr) begin
          s_d.st = ST_SW_DISABLED;
        end else if (rst_req && !lim_now && !error_active) begin
          s_d.st = ST_OP_ENABLED;
        end
      end
      ST_FAULT_REACT: begin
        // class 2 waits for standstill; 3 and 4 drop power at once
        if (s_q.react_cls != 3'd2 || standstill) begin
          s_d.st = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // class 4 latch outlives any fault reset, only reset clears it
        if (rst_req && !error_active && !s_q.latch4) begin
          s_d.st = ST_SW_DISABLED;
        end
      end
      default: s_d.st = ST_START;
    endcase
    // class 2 and up override the sequence from any state but start; class 1 only in 6 or 7, limit only in 6
    if (error_event && error_class >= 3'd2 && s_q.st != ST_START) begin
      s_d.st = ST_FAULT_REACT;
      s_d.react_cls = error_class;
      s_d.stop_cause = error_code;
      rec_err = 1'b1;
      rec_code = error_code;
      if (error_class >= 3'd4) begin
        s_d.latch4 = 1'b1;
      end
    end else if (error_event && error_class == 3'd1 &&
                 (s_q.st == ST_OP_ENABLED || s_q.st == ST_QSTOP)) begin
      s_d.st = ST_QSTOP;
      s_d.stop_cause = error_code;
      rec_err = 1'b1;
      rec_code = error_code;
    end else if (lim_now && !s_q.limit_prev && s_q.st == ST_OP_ENABLED) begin
      s_d.st = ST_QSTOP;
      s_d.stop_cause = `DSEC_CODE_LIMIT;
      rec_err = 1'b1;
      rec_code = `DSEC_CODE_LIMIT;
    end
    if (rec_err) begin
      hist_we = 1'b1;
      hist_wd = rec_code;
      s_d.last_err = rec_code;
      s_d.wptr = (s_q.wptr == 4'(HIST_DEPTH - 1)) ? 4'h0 : s_q.wptr + 4'h1;
      if (s_q.count != 4'(HIST_DEPTH)) begin
        s_d.count = s_q.count + 4'h1;
      end
    end
    // bus read: one-cycle registered memory read before rvalid
    rd_fire = s_axi_arvalid && !s_q.rpend && !s_q.rvalid;
    // launch the memory read with the address, so its data stand when rvalid is built
    hist_ra = 4'h0;
    if (rd_fire && s_axi_araddr >= `DSEC_OFS_HIST && s_axi_araddr <= `DSEC_HIST_LAST) begin
      hist_ra = hist_slot(s_q.wptr, 4'(s_axi_araddr[7:2] - 6'h10));
    end
    if (rd_fire) begin
      s_d.rpend = 1'b1;
      s_d.araddr = s_axi_araddr;
    end
    if (s_q.rpend) begin
      s_d.rpend = 1'b0;
      s_d.rvalid = 1'b1;
      if (s_q.araddr == `DSEC_OFS_STATE) begin
        s_d.rdata = {28'h0, s_q.st};
      end else if (s_q.araddr == `DSEC_OFS_CTRL) begin
        s_d.rdata = {26'h0, s_q.par_ok, s_q.elec_ok, s_q.halt, 3'h0};
      end else if (s_q.araddr == `DSEC_OFS_STOP) begin
        s_d.rdata = {16'h0, s_q.stop_cause};
      end else if (s_q.araddr == `DSEC_OFS_ERR) begin
        s_d.rdata = {16'h0, s_q.last_err};
      end else if (s_q.araddr == `DSEC_OFS_CNT) begin
        s_d.rdata = {28'h0, s_q.count};
      end else if (s_q.araddr >= `DSEC_OFS_HIST && s_q.araddr <= `DSEC_HIST_LAST) begin
        s_d.rdata = ({28'h0, s_q.count} > 32'(s_q.araddr[7:2] - 6'h10)) ?
                    {16'h0, hist_rd} : 32'h0000_0000;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= ST_START;
    end else if (aclken) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = 2'b00;
  assign s_axi_arready = !s_q.rpend && !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = 2'b00;

  assign op_state = s_q.st;
  // class 1 keeps power in quick stop; class 2 keeps it until standstill
  assign power_stage_en = s_q.st == ST_OP_ENABLED || s_q.st == ST_QSTOP ||
                          (s_q.st == ST_FAULT_REACT && s_q.react_cls == 3'd2);
  assign brake_release = power_stage_en;
  assign mode_run = s_q.st == ST_OP_ENABLED && !s_q.halt;
  assign quick_stop = s_q.st == ST_QSTOP ||
                      (s_q.st == ST_FAULT_REACT && s_q.react_cls == 3'd2);
  assign warning = s_q.warn;
  assign halted_indication = s_q.st == ST_OP_ENABLED && s_q.halt;
  assign fault_indication = s_q.st == ST_FAULT_REACT || s_q.st == ST_FAULT;
  assign ready_indication = s_q.st == ST_READY;
  assign display_code = s_q.stop_cause;
endmodule // dsec_core
`default_nettype wire

// File: rtl/dsec_hist_mem.sv
// ten-entry error history memory with registered read port
`timescale 1ns/10ps
`default_nettype none
module dsec_hist_mem #(
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic aclk,
  input wire logic aclken,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [DEPTH];
  always_ff @(posedge aclk) begin
    if (aclken) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 16'h0000;
    end
  end
endmodule // dsec_hist_mem
`default_nettype wire

// File: rtl/dsec_pkg.sv
// types of the drive state and error class block
package dsec_pkg;
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_NOT_READY = 4'h2,
    ST_SW_DISABLED = 4'h3,
    ST_READY = 4'h4,
    ST_SWITCHED_ON = 4'h5,
    ST_OP_ENABLED = 4'h6,
    ST_QSTOP = 4'h7,
    ST_FAULT_REACT = 4'h8,
    ST_FAULT = 4'h9
  } dsec_state_t;
  typedef logic [2:0] dsec_class_t;
endpackage

// File: rtl/dsec_regs.svh
// register offsets, field positions, history depth and codes of the drive state block
`ifndef DSEC_REGS_SVH
`define DSEC_REGS_SVH
`define DSEC_OFS_CTRL 8'h00
`define DSEC_OFS_STATE 8'h04
`define DSEC_OFS_STOP 8'h08
`define DSEC_OFS_ERR 8'h0C
`define DSEC_OFS_CNT 8'h10
`define DSEC_OFS_HIST 8'h40
`define DSEC_HIST_LAST 8'h64
`define DSEC_CTRL_ENABLE 0
`define DSEC_CTRL_DISABLE 1
`define DSEC_CTRL_RESET 2
`define DSEC_CTRL_HALT 3
`define DSEC_CTRL_ELEC_OK 4
`define DSEC_CTRL_PAR_OK 5
`define DSEC_CTRL_SW_STOP 6
`define DSEC_CODE_LIMIT 16'hA302
`define DSEC_CODE_SWSTOP 16'hA306
`define DSEC_HIST_DEPTH 10
`endif

// File: rtl/dsec_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module dsec_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aclken,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      dout <= '0;
    end else if (aclken) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // dsec_sync
`default_nettype wire

// File: test/dsec_core_asserts.sv
// port assertions of the drive state block
`timescale 1ns/10ps
`default_nettype none
`include "dsec_regs.svh"
module dsec_core_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic positive_limit_input,
  input wire logic error_event,
  input wire dsec_pkg::dsec_class_t error_class,
  input wire logic [15:0] error_code,
  input wire logic standstill,
  input wire dsec_pkg::dsec_state_t op_state,
  input wire logic power_stage_en,
  input wire logic brake_release,
  input wire logic mode_run,
  input wire logic quick_stop,
  input wire logic warning,
  input wire logic fault_indication,
  input wire logic ready_indication,
  input wire logic [15:0] display_code
);
  import dsec_pkg::*;
  logic cls4_q;
  // class 4 latch survives every fault reset, so track it here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cls4_q <= 1'b0;
    end else if (error_event && error_class == 3'h4 && op_state != ST_START) begin
      cls4_q <= 1'b1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_err(logic [2:0] c);
    error_event && error_class == c && op_state == ST_OP_ENABLED;
  endsequence
  sequence s_off_react;
    op_state == ST_FAULT_REACT && !power_stage_en;
  endsequence
  a_warn_only: assert property (s_err(3'h0) |=> warning && op_state == ST_OP_ENABLED)
    else $error("class 0 left run state");
  a_class1_qstop: assert property (s_err(3'h1) |=> op_state == ST_QSTOP
    && power_stage_en && display_code == $past(error_code))
    else $error("class 1 response wrong");
  a_class2_react: assert property (s_err(3'h2) |=> op_state == ST_FAULT_REACT
    && quick_stop && display_code == $past(error_code))
    else $error("class 2 response wrong");
  a_class2_wait: assert property (op_state == ST_FAULT_REACT && quick_stop && !standstill
    |=> op_state == ST_FAULT_REACT)
    else $error("fault reached before standstill");
  a_class3_off: assert property (s_err(3'h3) |=> s_off_react ##1 op_state == ST_FAULT)
    else $error("class 3 did not switch off");
  a_class4_hold: assert property (op_state == ST_FAULT && cls4_q |=> op_state == ST_FAULT)
    else $error("class 4 fault cleared");
  a_limit_qstop: assert property ($rose(positive_limit_input) && op_state == ST_OP_ENABLED
    |-> ##[1:4] (op_state == ST_QSTOP && display_code == `DSEC_CODE_LIMIT))
    else $error("limit trip not handled");
  a_auto_run: assert property (op_state == ST_SWITCHED_ON |=> op_state inside
    {ST_OP_ENABLED, ST_SW_DISABLED, ST_FAULT_REACT})
    else $error("switched on did not advance");
  a_run_power: assert property (op_state == ST_OP_ENABLED |-> power_stage_en && brake_release)
    else $error("run state without power");
  a_on_idle: assert property (op_state == ST_SWITCHED_ON |-> !mode_run && !power_stage_en)
    else $error("switched on drives motor");
  a_ready_flag: assert property (op_state == ST_READY |-> ready_indication)
    else $error("ready not shown");
  a_fault_flag: assert property (op_state inside {ST_FAULT_REACT, ST_FAULT} |-> fault_indication)
    else $error("fault not shown");
  a_reset_start: assert property (disable iff (1'b0) !aresetn |=> op_state == ST_START
    && display_code == 16'h0000)
    else $error("reset state wrong");
endmodule // dsec_core_asserts
bind dsec_core dsec_core_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .positive_limit_input(positive_limit_input), .error_event(error_event),
  .error_class(error_class), .error_code(error_code), .standstill(standstill),
  .op_state(op_state), .power_stage_en(power_stage_en), .brake_release(brake_release),
  .mode_run(mode_run), .quick_stop(quick_stop), .warning(warning),
  .fault_indication(fault_indication), .ready_indication(ready_indication),
  .display_code(display_code));
`default_nettype wire

// File: test/dsec_core_tb.sv
// self-checking bench of the drive state block
`timescale 1ns/10ps
`default_nettype none
`include "dsec_regs.svh"
module dsec_core_tb;
  import dsec_pkg::*;
  typedef struct packed {
    dsec_class_t cls; logic [15:0] code; dsec_state_t st; logic pse; logic rec;
  } dsec_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, fire = 1'b0, cen = 1'b1;
  logic plim = 1'b0, pok = 1'b0, ena = 1'b0, frst = 1'b0, eact = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, v;
  dsec_class_t cls = 3'h0, ecls;
  logic [15:0] code = 16'h0, ecode, disp;
  logic awr, wrdy, bv, arr, rv, ev, stand, pse, brk, run, qs, warn, halt, flt, rdy;
  logic [1:0] br, rr;
  dsec_state_t st;
  int fail_count = 0, check_count = 0, cyc = 0;
  dsec_row_t rows [4];
  dsec_core dut (
    .aclk(aclk), .aclken(cen), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .positive_limit_input(plim), .negative_limit_input(1'b0), .power_ok(pok),
    .enable_input(ena), .fault_reset_input(frst), .error_event(ev),
    .error_class(ecls), .error_code(ecode), .error_active(eact), .standstill(stand),
    .op_state(st), .power_stage_en(pse), .brake_release(brk), .mode_run(run),
    .quick_stop(qs), .warning(warn), .halted_indication(halt),
    .fault_indication(flt), .ready_indication(rdy), .display_code(disp));
  dsec_monitor_model mon (.aclk(aclk), .aresetn(aresetn), .fire(fire), .cls(cls),
    .code(code), .quick_stop(qs), .power_stage_en(pse), .error_event(ev),
    .error_class(ecls), .error_code(ecode), .standstill(stand));
  always #12.5 aclk = ~aclk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bready and rready stay high, so the answer is taken at its first edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awv && awr;
      hw = wv && wrdy;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!((ha || !awv) && (hw || !wv)));
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic h;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge aclk);
      h = arr;
      @(posedge aclk);
    end while (!h);
    arv <= 1'b0;
    do @(negedge aclk); while (!rv);
    d = rd;
    @(posedge aclk);
  endtask
  task automatic wait_st(input dsec_state_t s);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (st !== s && n < 80);
    chk(st, s, "state");
  endtask
  task automatic fire_err(input dsec_class_t c, input logic [15:0] k);
    @(posedge aclk);
    cls <= c;
    code <= k;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    cycles(3);
  endtask
  task automatic freset();
    @(posedge aclk);
    frst <= 1'b1;
    cycles(4);
    frst <= 1'b0;
  endtask
  task automatic go_run();
    @(posedge aclk);
    pok <= 1'b1;
    ena <= 1'b1;
    wait_st(ST_OP_ENABLED);
    @(posedge aclk);
    ena <= 1'b0;
  endtask
  initial begin
    rows[0] = '{3'h0, 16'h8100, ST_OP_ENABLED, 1'b1, 1'b0};
    rows[1] = '{3'h1, 16'hA320, ST_QSTOP, 1'b1, 1'b1};
    rows[2] = '{3'h2, 16'h8320, ST_FAULT, 1'b0, 1'b1};
    rows[3] = '{3'h3, 16'h8330, ST_FAULT, 1'b0, 1'b1};
    cycles(16);
    chk(st, ST_START, "start");
    aresetn <= 1'b1;
    axi_wr(`DSEC_OFS_CTRL, 32'h10);
    wait_st(ST_NOT_READY);
    axi_wr(`DSEC_OFS_CTRL, 32'h30);
    wait_st(ST_SW_DISABLED);
    axi_wr(`DSEC_OFS_CTRL, 32'h31);
    cycles(4);
    chk(st, ST_SW_DISABLED, "enable blocked");
    pok <= 1'b1;
    wait_st(ST_READY);
    chk(rdy, 1'b1, "ready flag");
    axi_wr(`DSEC_OFS_CTRL, 32'h31);
    wait_st(ST_OP_ENABLED);
    chk(pse & brk, 1'b1, "power and brake");
    foreach (rows[i]) begin
      fire_err(rows[i].cls, rows[i].code);
      wait_st(rows[i].st);
      chk(pse, rows[i].pse, "power stage");
      if (rows[i].rec) begin
        axi_rd(`DSEC_OFS_STOP, v);
        chk(v, {16'h0, rows[i].code}, "stop cause");
        axi_rd(`DSEC_OFS_HIST, v);
        chk(v, {16'h0, rows[i].code}, "newest entry");
        chk(disp, rows[i].code, "display");
        // power held off so state 3 stands long enough to be seen
        pok <= (rows[i].st != ST_FAULT);
        freset();
        if (rows[i].st == ST_FAULT) begin
          wait_st(ST_SW_DISABLED);
          go_run();
        end else begin
          wait_st(ST_OP_ENABLED);
        end
      end else begin
        chk(warn, 1'b1, "warning");
      end
    end
    eact <= 1'b1;
    fire_err(3'h3, 16'h8331);
    freset();
    cycles(4);
    chk(st, ST_FAULT, "reset while cause present");
    eact <= 1'b0;
    pok <= 1'b0;
    freset();
    wait_st(ST_SW_DISABLED);
    go_run();
    plim <= 1'b1;
    wait_st(ST_QSTOP);
    axi_rd(`DSEC_OFS_HIST, v);
    chk(v, {16'h0, `DSEC_CODE_LIMIT}, "limit entry");
    plim <= 1'b0;
    freset();
    wait_st(ST_OP_ENABLED);
    axi_wr(`DSEC_OFS_CTRL, 32'h38);
    cycles(3);
    chk({halt, pse}, 2'b11, "halt");
    axi_rd(`DSEC_OFS_STOP, v);
    chk(v, {16'h0, `DSEC_CODE_LIMIT}, "halt records nothing");
    axi_wr(`DSEC_OFS_CTRL, 32'h30);
    for (int k = 0; k < 11; k++) begin
      fire_err(3'h1, 16'hA400 + k[15:0]);
    end
    axi_rd(`DSEC_OFS_CNT, v);
    chk(v, 32'hA, "history count");
    axi_rd(`DSEC_OFS_HIST, v);
    chk(v, 32'hA40A, "newest");
    axi_rd(`DSEC_HIST_LAST, v);
    chk(v, 32'hA401, "oldest kept");
    // unmapped access must not disturb the state
    axi_wr(8'h3C, 32'hFFFFFFFF);
    axi_rd(8'h3C, v);
    chk(v, 32'h0, "unmapped read");
    axi_rd(`DSEC_OFS_STATE, v);
    chk(v, 32'h7, "state readout");
    freset();
    wait_st(ST_OP_ENABLED);
    axi_wr(`DSEC_OFS_CTRL, 32'h70);
    wait_st(ST_QSTOP);
    axi_rd(`DSEC_OFS_STOP, v);
    chk(v, {16'h0, `DSEC_CODE_SWSTOP}, "software stop cause");
    axi_wr(`DSEC_OFS_CTRL, 32'h32);
    wait_st(ST_READY);
    go_run();
    // low clock enable must swallow a monitor event
    cen <= 1'b0;
    fire_err(3'h4, 16'h8340);
    chk(st, ST_OP_ENABLED, "frozen");
    cen <= 1'b1;
    fire_err(3'h4, 16'h8340);
    wait_st(ST_FAULT);
    freset();
    cycles(4);
    chk(st, ST_FAULT, "class 4 held");
    aresetn <= 1'b0;
    cycles(2);
    chk({st, disp}, {ST_START, 16'h0}, "second reset");
    aresetn <= 1'b1;
    give_verdict();
  end
endmodule // dsec_core_tb
`default_nettype wire

// File: test/dsec_monitor_model.sv
// monitoring side model: error events and motor standstill
`timescale 1ns/10ps
`default_nettype none
module dsec_monitor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire dsec_pkg::dsec_class_t cls,
  input wire logic [15:0] code,
  input wire logic quick_stop,
  input wire logic power_stage_en,
  output logic error_event,
  output dsec_pkg::dsec_class_t error_class,
  output logic [15:0] error_code,
  output logic standstill
);
  import dsec_pkg::*;
  logic [2:0] ramp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_event <= 1'b0;
      error_class <= 3'h0;
      error_code <= 16'h0000;
      ramp_q <= 3'h0;
      standstill <= 1'b1;
    end else begin
      error_event <= fire;
      // idle payload keeps moving so a stale value is never mistaken for valid
      error_class <= fire ? cls : ~error_class;
      error_code <= fire ? code : ~error_code;
      ramp_q <= quick_stop ? ramp_q + {2'b00, ramp_q != 3'h7} : 3'h0;
      // braking takes several cycles, not instant
      standstill <= !power_stage_en || ramp_q == 3'h6;
    end
  end
endmodule // dsec_monitor_model
`default_nettype wire
